// [hdl/iepb_defines.svh]
// named constants for the interrupt enable/priority bank and its bit space
// assumes inclusion by bare name from the module files
`ifndef IEPB_DEFINES_SVH
`define IEPB_DEFINES_SVH

`define IEPB_NUM_SFR 20
`define IEPB_NUM_BIT_SFR 11
`define IEPB_RAM_BYTES 16
`define IEPB_RAM_BASE 8'h20
`define IEPB_RAM_LAST 8'h2f

// bit-addressable register byte addresses
`define IEPB_ADDR_PORT0 8'h80
`define IEPB_ADDR_TIMER_CTRL 8'h88
`define IEPB_ADDR_PORT1 8'h90
`define IEPB_ADDR_SERIAL_CTRL 8'h98
`define IEPB_ADDR_PORT2 8'ha0
`define IEPB_ADDR_INT_EN 8'ha8
`define IEPB_ADDR_PORT3 8'hb0
`define IEPB_ADDR_INT_PRIO 8'hb8
`define IEPB_ADDR_STATUS_WORD 8'hd0
`define IEPB_ADDR_ACC 8'he0
`define IEPB_ADDR_BREG 8'hf0

// reserved bit-addressable byte addresses
`define IEPB_RSVD_0 8'hc0
`define IEPB_RSVD_1 8'hc8
`define IEPB_RSVD_2 8'hd8
`define IEPB_RSVD_3 8'he8
`define IEPB_RSVD_4 8'hf8

// slot index in the storage table of each register other than the four ports
`define IEPB_SLOT_TIMER_CTRL 1
`define IEPB_SLOT_SERIAL_CTRL 3
`define IEPB_SLOT_INT_EN 5
`define IEPB_SLOT_INT_PRIO 7
`define IEPB_SLOT_STATUS_WORD 8
`define IEPB_SLOT_ACC 9
`define IEPB_SLOT_BREG 10

// source positions shared by enable and priority registers
`define IEPB_SRC_EXT0 0
`define IEPB_SRC_TIMER0 1
`define IEPB_SRC_EXT1 2
`define IEPB_SRC_TIMER1 3
`define IEPB_SRC_SERIAL 4
`define IEPB_GLOBAL_EN_BIT 7
`define IEPB_INT_EN_WMASK 8'h9f
`define IEPB_INT_PRIO_WMASK 8'h1f
`define IEPB_FULL_WMASK 8'hff
`define IEPB_RESET_VALUE 8'h00

// event flag positions
`define IEPB_TIMER1_FLAG_BIT 7
`define IEPB_TIMER0_FLAG_BIT 5
`define IEPB_EXT1_FLAG_BIT 3
`define IEPB_EXT0_FLAG_BIT 1
`define IEPB_TX_DONE_BIT 1
`define IEPB_RX_DONE_BIT 0
`define IEPB_CARRY_BIT 7

`endif

// [hdl/iepb_pkg.sv]
// shared types of the interrupt enable/priority bank
// assumes the defines header is on the include path
package iepb_pkg;
	typedef logic [7:0] iepb_byte_t;
	// what a decoded request address lands on
	typedef enum logic [1:0] {
		IEPB_TGT_NONE,
		IEPB_TGT_RAM,
		IEPB_TGT_SFR,
		IEPB_TGT_RSVD
	} iepb_tgt_t;
endpackage

// [hdl/iepb_bit_if.sv]
// carrier between the bank and one bit-addressable storage byte
// assumes one controller and one storage end per instance
`timescale 1ns/1ps
interface iepb_bit_if;
	logic byte_we;
	logic bit_we;
	logic [2:0] bit_sel;
	logic bit_val;
	logic [7:0] wdata;
	logic [7:0] hw_set;
	logic [7:0] hw_clr;
	logic [7:0] q;
	modport store (input byte_we, input bit_we, input bit_sel, input bit_val, input wdata,
		input hw_set, input hw_clr, output q);
	modport ctl (output byte_we, output bit_we, output bit_sel, output bit_val, output wdata,
		output hw_set, output hw_clr, input q);
endinterface

// [hdl/iepb_bitreg.sv]
// one byte of storage reachable as a byte or as single bits
// assumes writes and hardware events arrive on core_clk
`timescale 1ns/1ps
`include "iepb_defines.svh"
module iepb_bitreg #(
	parameter logic [7:0] WMASK = `IEPB_FULL_WMASK,
	parameter logic [7:0] RST = `IEPB_RESET_VALUE
) (
	input wire logic core_clk,
	input wire logic srst,
	iepb_bit_if.store bus
);
	logic [7:0] q_reg;
	logic [7:0] q_next;

	// software write first, then hardware clear and set; set wins last
	always_comb begin
		q_next = q_reg;
		if (bus.byte_we) begin
			q_next = bus.wdata;
		end else if (bus.bit_we) begin
			q_next[bus.bit_sel] = bus.bit_val;
		end
		q_next = ((q_next & ~bus.hw_clr) | bus.hw_set) & WMASK; // reserved bits stay zero
	end

	// storage byte
	always_ff @(posedge core_clk) begin
		if (srst) begin
			q_reg <= RST & WMASK;
		end else begin
			q_reg <= q_next;
		end
	end

	assign bus.q = q_reg;

	set_wins_a: assert property (@(posedge core_clk) disable iff (srst)
		(bus.hw_set != 8'h00) |=> ((q_reg & $past(bus.hw_set & WMASK)) == $past(bus.hw_set & WMASK)))
		else $error("hardware set lost against a same-cycle clear");
endmodule

// [hdl/iepb_top.sv]
// interrupt enable/priority bank with the bit-addressable register and flag space
// assumes requests, events and carry updates come from core logic on core_clk
`timescale 1ns/1ps
`include "iepb_defines.svh"
module iepb_top (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_bit,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_wdata,
	input wire logic timer0_overflow,
	input wire logic timer1_overflow,
	input wire logic ext0_event,
	input wire logic ext1_event,
	input wire logic serial_tx_done,
	input wire logic serial_rx_done,
	input wire logic alu_carry_we,
	input wire logic alu_carry_val,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic rd_err,
	output logic irq_req,
	output logic [4:0] irq_high,
	output logic [4:0] irq_low,
	output logic carry_flag
);
	localparam int NSLOT = `IEPB_NUM_BIT_SFR;
	// storage table of the bit-addressable registers; byte-only addresses decode to no target
	localparam logic [7:0] SLOT_ADDR [NSLOT] = '{
		`IEPB_ADDR_PORT0, `IEPB_ADDR_TIMER_CTRL, `IEPB_ADDR_PORT1, `IEPB_ADDR_SERIAL_CTRL,
		`IEPB_ADDR_PORT2, `IEPB_ADDR_INT_EN, `IEPB_ADDR_PORT3, `IEPB_ADDR_INT_PRIO,
		`IEPB_ADDR_STATUS_WORD, `IEPB_ADDR_ACC, `IEPB_ADDR_BREG};
	localparam logic [7:0] SLOT_WMASK [NSLOT] = '{
		`IEPB_FULL_WMASK, `IEPB_FULL_WMASK, `IEPB_FULL_WMASK, `IEPB_FULL_WMASK,
		`IEPB_FULL_WMASK, `IEPB_INT_EN_WMASK, `IEPB_FULL_WMASK, `IEPB_INT_PRIO_WMASK,
		`IEPB_FULL_WMASK, `IEPB_FULL_WMASK, `IEPB_FULL_WMASK};

	iepb_pkg::iepb_byte_t byte_addr;
	iepb_pkg::iepb_tgt_t tgt;
	logic [NSLOT-1:0] slot_hit;
	logic [3:0] slot_idx;
	logic [7:0] slot_q [NSLOT];
	logic [7:0] slot_set [NSLOT];
	logic [7:0] slot_clr [NSLOT];
	logic [7:0] ram_reg [`IEPB_RAM_BYTES];
	logic [7:0] rsel;
	logic [7:0] rd_data_next;
	logic [7:0] int_en;
	logic [7:0] int_prio;
	logic [4:0] src;
	logic [4:0] active;
	logic [4:0] irq_high_reg;
	logic [4:0] irq_low_reg;
	logic irq_req_reg;
	logic rd_valid_reg;
	logic rd_err_reg;
	logic [7:0] rd_data_reg;
	logic wr_ram;

	// bit address to byte address: low half is the RAM flag area, high half the registers
	always_comb begin
		if (!req_bit) begin
			byte_addr = req_addr;
		end else if (req_addr[7]) begin
			byte_addr = {req_addr[7:3], 3'h0};
		end else begin
			byte_addr = `IEPB_RAM_BASE + {4'h0, req_addr[6:3]};
		end
	end

	// target decode; reserved addresses are known but hold nothing
	always_comb begin
		slot_idx = 4'h0;
		for (int i = 0; i < NSLOT; i++) begin
			slot_hit[i] = (byte_addr == SLOT_ADDR[i]);
			if (slot_hit[i]) begin
				slot_idx = 4'(i);
			end
		end
		if (byte_addr >= `IEPB_RAM_BASE && byte_addr <= `IEPB_RAM_LAST) begin
			tgt = iepb_pkg::IEPB_TGT_RAM;
		end else if (|slot_hit) begin
			tgt = iepb_pkg::IEPB_TGT_SFR;
		end else if (byte_addr == `IEPB_RSVD_0 || byte_addr == `IEPB_RSVD_1 || byte_addr == `IEPB_RSVD_2 ||
			byte_addr == `IEPB_RSVD_3 || byte_addr == `IEPB_RSVD_4) begin
			tgt = iepb_pkg::IEPB_TGT_RSVD;
		end else begin
			tgt = iepb_pkg::IEPB_TGT_NONE;
		end
	end

	// hardware events into their flags, and the alu carry into the status word
	always_comb begin
		for (int i = 0; i < NSLOT; i++) begin
			slot_set[i] = 8'h00;
			slot_clr[i] = 8'h00;
		end
		slot_set[`IEPB_SLOT_TIMER_CTRL][`IEPB_TIMER1_FLAG_BIT] = timer1_overflow;
		slot_set[`IEPB_SLOT_TIMER_CTRL][`IEPB_TIMER0_FLAG_BIT] = timer0_overflow;
		slot_set[`IEPB_SLOT_TIMER_CTRL][`IEPB_EXT1_FLAG_BIT] = ext1_event;
		slot_set[`IEPB_SLOT_TIMER_CTRL][`IEPB_EXT0_FLAG_BIT] = ext0_event;
		slot_set[`IEPB_SLOT_SERIAL_CTRL][`IEPB_TX_DONE_BIT] = serial_tx_done;
		slot_set[`IEPB_SLOT_SERIAL_CTRL][`IEPB_RX_DONE_BIT] = serial_rx_done;
		slot_set[`IEPB_SLOT_STATUS_WORD][`IEPB_CARRY_BIT] = alu_carry_we & alu_carry_val;
		slot_clr[`IEPB_SLOT_STATUS_WORD][`IEPB_CARRY_BIT] = alu_carry_we & ~alu_carry_val;
	end

	// one storage byte per bit-addressable register; carry sits inside the status word
	iepb_bit_if slot_bus [NSLOT] ();
	for (genvar g = 0; g < NSLOT; g++) begin : g_slot
		assign slot_bus[g].byte_we = req_valid & req_write & ~req_bit & slot_hit[g];
		assign slot_bus[g].bit_we = req_valid & req_write & req_bit & slot_hit[g];
		assign slot_bus[g].bit_sel = req_addr[2:0];
		assign slot_bus[g].bit_val = req_wdata[0];
		assign slot_bus[g].wdata = req_wdata;
		assign slot_bus[g].hw_set = slot_set[g];
		assign slot_bus[g].hw_clr = slot_clr[g];
		assign slot_q[g] = slot_bus[g].q;
		iepb_bitreg #(
			.WMASK(SLOT_WMASK[g]),
			.RST(`IEPB_RESET_VALUE)
		) u_reg (
			.core_clk(core_clk),
			.srst(srst),
			.bus(slot_bus[g])
		);
	end

	// flag RAM, byte or bit wide; no reset is needed for plain flags but keeps sim clean
	assign wr_ram = req_valid & req_write & (tgt == iepb_pkg::IEPB_TGT_RAM);
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < `IEPB_RAM_BYTES; i++) begin
				ram_reg[i] <= `IEPB_RESET_VALUE;
			end
		end else if (wr_ram && req_bit) begin
			ram_reg[byte_addr[3:0]][req_addr[2:0]] <= req_wdata[0];
		end else if (wr_ram) begin
			ram_reg[byte_addr[3:0]] <= req_wdata;
		end
	end

	// read mux; reserved and unknown addresses read zero and flag an error
	always_comb begin
		unique case (tgt)
			iepb_pkg::IEPB_TGT_RAM: rsel = ram_reg[byte_addr[3:0]];
			iepb_pkg::IEPB_TGT_SFR: rsel = slot_q[slot_idx];
			iepb_pkg::IEPB_TGT_RSVD: rsel = 8'h00;
			iepb_pkg::IEPB_TGT_NONE: rsel = 8'h00;
		endcase
		rd_data_next = req_bit ? {7'h00, rsel[req_addr[2:0]]} : rsel;
	end

	// answer one cycle after every request, read or write
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_valid_reg <= 1'b0;
			rd_err_reg <= 1'b0;
			rd_data_reg <= 8'h00;
		end else begin
			rd_valid_reg <= req_valid;
			rd_err_reg <= req_valid & ((tgt == iepb_pkg::IEPB_TGT_RSVD) | (tgt == iepb_pkg::IEPB_TGT_NONE));
			rd_data_reg <= (req_valid && !req_write) ? rd_data_next : 8'h00;
		end
	end

	// interrupt sources, gated by their own enable and then the global one
	assign int_en = slot_q[`IEPB_SLOT_INT_EN];
	assign int_prio = slot_q[`IEPB_SLOT_INT_PRIO];
	assign src[`IEPB_SRC_EXT0] = slot_q[`IEPB_SLOT_TIMER_CTRL][`IEPB_EXT0_FLAG_BIT];
	assign src[`IEPB_SRC_TIMER0] = slot_q[`IEPB_SLOT_TIMER_CTRL][`IEPB_TIMER0_FLAG_BIT];
	assign src[`IEPB_SRC_EXT1] = slot_q[`IEPB_SLOT_TIMER_CTRL][`IEPB_EXT1_FLAG_BIT];
	assign src[`IEPB_SRC_TIMER1] = slot_q[`IEPB_SLOT_TIMER_CTRL][`IEPB_TIMER1_FLAG_BIT];
	assign src[`IEPB_SRC_SERIAL] = slot_q[`IEPB_SLOT_SERIAL_CTRL][`IEPB_TX_DONE_BIT] |
		slot_q[`IEPB_SLOT_SERIAL_CTRL][`IEPB_RX_DONE_BIT];
	assign active = src & int_en[4:0] & {5{int_en[`IEPB_GLOBAL_EN_BIT]}};

	// split by priority; registered so the core sees a clean level
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_high_reg <= 5'h00;
			irq_low_reg <= 5'h00;
			irq_req_reg <= 1'b0;
		end else begin
			irq_high_reg <= active & int_prio[4:0];
			irq_low_reg <= active & ~int_prio[4:0];
			irq_req_reg <= |active;
		end
	end

	assign rd_valid = rd_valid_reg;
	assign rd_err = rd_err_reg;
	assign rd_data = rd_data_reg;
	assign irq_req = irq_req_reg;
	assign irq_high = irq_high_reg;
	assign irq_low = irq_low_reg;
	assign carry_flag = slot_q[`IEPB_SLOT_STATUS_WORD][`IEPB_CARRY_BIT];

	serial_gate_a: assert property (@(posedge core_clk) disable iff (srst)
		(irq_high[4] | irq_low[4]) |-> ($past(int_en[4]) && $past(src[4])))
		else $error("serial interrupt without its enable");
	timer1_gate_a: assert property (@(posedge core_clk) disable iff (srst)
		($past(src[3]) && $past(int_en[7]) && !$past(srst)) |-> ((irq_high[3] | irq_low[3]) == $past(int_en[3])))
		else $error("timer1 interrupt does not follow its enable");
	bit_sfr_a: assert property (@(posedge core_clk) disable iff (srst)
		(req_valid && req_bit && req_addr[7] && (|slot_hit)) |=> (rd_valid && !rd_err))
		else $error("bit access to an implemented register refused");
	reserved_addr_a: assert property (@(posedge core_clk) disable iff (srst)
		(req_valid && tgt == iepb_pkg::IEPB_TGT_RSVD) |=> (rd_err && rd_data == 8'h00))
		else $error("reserved address answered as implemented");
	acc_bit_a: assert property (@(posedge core_clk) disable iff (srst)
		(req_valid && req_write && req_bit && req_addr[7:3] == `IEPB_ADDR_ACC >> 3) |=>
		(slot_q[`IEPB_SLOT_ACC][$past(req_addr[2:0])] == $past(req_wdata[0])))
		else $error("accumulator bit write lost");
	ram_bit_a: assert property (@(posedge core_clk) disable iff (srst)
		(req_valid && req_write && req_bit && !req_addr[7]) |=>
		(ram_reg[$past(req_addr[6:3])][$past(req_addr[2:0])] == $past(req_wdata[0])))
		else $error("flag RAM bit write lost");
	carry_byte_a: assert property (@(posedge core_clk) disable iff (srst)
		(req_valid && req_write && !req_bit && req_addr == `IEPB_ADDR_STATUS_WORD && !alu_carry_we) |=>
		(carry_flag == $past(req_wdata[7])))
		else $error("status word byte write did not move carry");
	global_gate_a: assert property (@(posedge core_clk) disable iff (srst)
		(!int_en[7]) [*2] |-> (!irq_req && irq_high == 5'h00 && irq_low == 5'h00))
		else $error("interrupt raised with global enable clear");
	prio_split_a: assert property (@(posedge core_clk) disable iff (srst)
		((irq_high & irq_low) == 5'h00) && (irq_high == 5'h00 || $past(int_prio[4:0]) != 5'h00) &&
		int_en[6:5] == 2'h0 && int_prio[7:5] == 3'h0)
		else $error("priority split or reserved bits wrong");
endmodule

// [verif/iepb_tb_top.sv]
// self-checking bench for the interrupt enable/priority bank
// assumes the defines header on the include path; drives every port of iepb_top directly
`timescale 1ns/1ps
module iepb_tb_top;
	// one table row: request fields beside the answer they should give
	typedef struct packed {
		logic w;
		logic b;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] exp;
		logic err;
	} iepb_row_t;
	localparam int DRV = 1;
	logic core_clk, srst, req_valid, req_write, req_bit, alu_carry_we, alu_carry_val;
	logic [7:0] req_addr, req_wdata, rd_data, gd, m;
	logic rd_valid, rd_err, irq_req, carry_flag, ge, gv;
	logic [4:0] irq_high, irq_low;
	logic [5:0] ev;
	int fails, n_compared, sb;
	iepb_row_t rows [24] = '{
		'{1'b1, 1'b0, 8'ha8, 8'hff, 8'h00, 1'b0}, '{1'b0, 1'b0, 8'ha8, 8'h00, 8'h9f, 1'b0},
		'{1'b1, 1'b0, 8'hb8, 8'hff, 8'h00, 1'b0}, '{1'b0, 1'b0, 8'hb8, 8'h00, 8'h1f, 1'b0},
		'{1'b1, 1'b0, 8'he0, 8'ha5, 8'h00, 1'b0}, '{1'b0, 1'b1, 8'he0, 8'h00, 8'h01, 1'b0},
		'{1'b1, 1'b1, 8'he1, 8'h01, 8'h00, 1'b0}, '{1'b0, 1'b0, 8'he0, 8'h00, 8'ha7, 1'b0},
		'{1'b1, 1'b1, 8'hf7, 8'h01, 8'h00, 1'b0}, '{1'b0, 1'b0, 8'hf0, 8'h00, 8'h80, 1'b0},
		'{1'b1, 1'b1, 8'h7f, 8'h01, 8'h00, 1'b0}, '{1'b0, 1'b0, 8'h2f, 8'h00, 8'h80, 1'b0},
		'{1'b1, 1'b1, 8'h00, 8'h01, 8'h00, 1'b0}, '{1'b0, 1'b0, 8'h20, 8'h00, 8'h01, 1'b0},
		'{1'b0, 1'b0, 8'hc0, 8'h00, 8'h00, 1'b1}, '{1'b0, 1'b0, 8'hc8, 8'h00, 8'h00, 1'b1},
		'{1'b0, 1'b0, 8'hd8, 8'h00, 8'h00, 1'b1}, '{1'b0, 1'b0, 8'he8, 8'h00, 8'h00, 1'b1},
		'{1'b0, 1'b0, 8'hf8, 8'h00, 8'h00, 1'b1}, '{1'b1, 1'b0, 8'hc0, 8'hff, 8'h00, 1'b1},
		'{1'b1, 1'b1, 8'hc3, 8'h01, 8'h00, 1'b1}, '{1'b0, 1'b0, 8'h81, 8'h00, 8'h00, 1'b1},
		'{1'b0, 1'b0, 8'h30, 8'h00, 8'h00, 1'b1}, '{1'b0, 1'b0, 8'h98, 8'h00, 8'h00, 1'b0}
	};

	iepb_top u_dut (
		.core_clk(core_clk), .srst(srst), .req_valid(req_valid), .req_write(req_write), .req_bit(req_bit),
		.req_addr(req_addr), .req_wdata(req_wdata), .ext0_event(ev[0]), .timer0_overflow(ev[1]),
		.ext1_event(ev[2]), .timer1_overflow(ev[3]), .serial_tx_done(ev[4]), .serial_rx_done(ev[5]),
		.alu_carry_we(alu_carry_we), .alu_carry_val(alu_carry_val), .rd_valid(rd_valid), .rd_data(rd_data),
		.rd_err(rd_err), .irq_req(irq_req), .irq_high(irq_high), .irq_low(irq_low), .carry_flag(carry_flag)
	);

	// free-running core clock, 25 ns period
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic give_verdict;
		if (fails == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask

	// one request; answer is sampled in the cycle after the taking edge
	task automatic access(input logic w, input logic b, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #DRV;
		req_valid = 1'b1;
		req_write = w;
		req_bit = b;
		req_addr = a;
		req_wdata = d;
		@(posedge core_clk) #DRV;
		req_valid = 1'b0;
		gv = rd_valid;
		gd = rd_data;
		ge = rd_err;
	endtask

	// irq outputs lag a cause by two edges; three leaves margin
	task automatic settle;
		repeat (3) @(posedge core_clk);
		#DRV;
	endtask

	task automatic pulse(input int s);
		@(posedge core_clk) #DRV;
		ev[s] = 1'b1;
		@(posedge core_clk) #DRV;
		ev[s] = 1'b0;
	endtask

	// watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		give_verdict();
	end

	// main sequence
	initial begin
		fails = 0;
		n_compared = 0;
		srst = 1'b1;
		{req_valid, req_write, req_bit, alu_carry_we, alu_carry_val} = '0;
		req_addr = 8'h00;
		req_wdata = 8'h00;
		ev = '0;
		repeat (12) @(posedge core_clk);
		#DRV;
		srst = 1'b0;
		chk("irq_req", 8'h00, {7'h00, irq_req});
		access(1'b0, 1'b0, 8'ha8, 8'h00);
		chk("reset enable", 8'h00, gd);
		foreach (rows[i]) begin
			access(rows[i].w, rows[i].b, rows[i].a, rows[i].d);
			chk("rd_valid", 8'h01, {7'h00, gv});
			chk("rd_data", rows[i].exp, gd);
			chk("rd_err", {7'h00, rows[i].err}, {7'h00, ge});
		end
		// the table left every priority bit set; start the source walk from low priority
		access(1'b1, 1'b0, 8'hb8, 8'h00);
		// every source: gated by its enable, by the global enable, steered by priority
		for (int s = 0; s < 6; s++) begin
			sb = (s == 5) ? 4 : s;
			m = 8'h01 << sb;
			access(1'b1, 1'b0, 8'h88, 8'h00);
			access(1'b1, 1'b0, 8'h98, 8'h00);
			access(1'b1, 1'b0, 8'ha8, 8'h9f & ~m);
			pulse(s);
			settle();
			chk("irq_req off", 8'h00, {7'h00, irq_req});
			access(1'b1, 1'b0, 8'ha8, 8'h80 | m);
			settle();
			chk("irq_req on", 8'h01, {7'h00, irq_req});
			chk("irq_low", m, {3'h0, irq_low});
			access(1'b1, 1'b0, 8'hb8, m);
			settle();
			chk("irq_high", m, {3'h0, irq_high});
			chk("irq_low hp", 8'h00, {3'h0, irq_low});
			access(1'b1, 1'b1, 8'haf, 8'h00);
			settle();
			chk("irq_req global", 8'h00, {7'h00, irq_req});
			chk("irq_high global", 8'h00, {3'h0, irq_high});
			access(1'b1, 1'b0, 8'hb8, 8'h00);
		end
		// timer1 overflow lands on the same edge as a software clear of its flag; the set must win
		fork
			access(1'b1, 1'b0, 8'h88, 8'h00);
			pulse(3);
		join
		access(1'b0, 1'b0, 8'h88, 8'h00);
		chk("set wins", 8'h80, gd);
		// carry tracks status word bit 7; hardware load beats a same-cycle byte write
		alu_carry_we = 1'b1;
		access(1'b1, 1'b0, 8'hd0, 8'h80);
		alu_carry_we = 1'b0;
		chk("carry alu wins", 8'h00, {7'h00, carry_flag});
		access(1'b1, 1'b0, 8'hd0, 8'h81);
		chk("carry byte", 8'h01, {7'h00, carry_flag});
		access(1'b0, 1'b0, 8'hd0, 8'h00);
		chk("status word", 8'h81, gd);
		access(1'b1, 1'b0, 8'hd0, 8'h01);
		chk("carry cleared", 8'h00, {7'h00, carry_flag});
		// second reset in mid-run
		access(1'b1, 1'b0, 8'ha8, 8'h9f);
		@(posedge core_clk) #DRV;
		srst = 1'b1;
		repeat (2) @(posedge core_clk);
		#DRV;
		srst = 1'b0;
		chk("rd_valid rst", 8'h00, {7'h00, rd_valid});
		access(1'b0, 1'b0, 8'ha8, 8'h00);
		chk("enable after reset", 8'h00, gd);
		give_verdict();
	end
endmodule
